//--- rtl/data_eeprom_access_ctrl.sv
// data eeprom access controller: address, data, control and key registers
// assumes a classic wishbone master and a self-timed byte array behind it
// assumes software keeps the two key writes and the trigger together
// external port pins arrive asynchronously and are synchronised here
//
// Contract
// - read: load address, clear program select, set read; data valid next cycle
// - data register holds last read until next read or software write
// - write starts only after keys 55h, 0AAh then write trigger, every byte
// - write trigger refused unless write permit is already set
// - hardware never clears write permit except at power-up
// - control, address and data registers locked while a write runs
// - setting permit and trigger in one write starts no write
// - on write completion clear trigger and set write-done flag
// - write-done flag only cleared by software; poll or enable interrupt
// - code protect blocks external programming-port reads and writes
// - internal cpu reads and writes work regardless of code protect
// - write permit cleared on power-up
// - all writes blocked while the power-up hold timer runs
// - read completes in one cycle; refused when program or config select set
// - abort flag set on reset-ended or improper write; selects kept
// - unlock key port has no storage and reads as zero
// - 8-bit address selects one of 256 bytes
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_consts.svh"

module data_eeprom_access_ctrl #(
   parameter int PROG_CYCLES = `PROG_CYCLES,
   parameter int PWRT_CYCLES = `PWRT_CYCLES
) (
   // clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_n_i,
   // wishbone slave
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   output logic                        ack_o,
   // configuration and status
   input  wire logic                   code_protect_i,
   input  wire logic                   write_aborted_by_reset_i,
   // external programming port and write-done interrupt
   input  wire nv_access_pkg::ext_req_t ext_req_i,
   output logic      [7:0]             ext_rdata_o,
   output logic                        ext_blocked_o,
   output logic                        write_done_irq_o
);
   import nv_access_pkg::*;

   // one counter width serves both timers, whichever is longer
   localparam int CW = $clog2(((PWRT_CYCLES > PROG_CYCLES) ? PWRT_CYCLES : PROG_CYCLES) + 1) + 1;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  data;
      logic        prog_sel;
      logic        cfg_sel;
      logic        row_erase;
      logic        abort;
      logic        permit;
      logic        wr;
      logic        rd;
      logic        rd_land;
      logic        ext_land;
      key_state_t  key;
      nv_state_t   nv;
      logic [CW-1:0] prog_cnt;
      logic [CW-1:0] pwrt_cnt;
      logic        pwrt_done;
      logic [7:0]  irq_prio;
      logic [7:0]  irq_flags;
      logic [7:0]  irq_en;
      logic        ack;
      logic [7:0]  rdat;
      logic [7:0]  ext_rdata;
      logic        ext_blocked;
      // whole request crosses together; third stage only for the edge
      ext_req_t    ext_q1;
      ext_req_t    ext_q2;
      logic        ext_q3;
      logic        cp_q1;
      logic        cp_q2;
      logic        abrst_q1;
      logic        abrst_q2;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic        arr_we;
   logic [7:0]  arr_addr;
   logic [7:0]  arr_wdata;
   logic [7:0]  arr_rdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  wb;
   logic        busy;
   logic        ext_go;
   logic [CW-1:0] half_prog;
   // decoded bus strobe and gated trigger conditions
   logic        bus_take;
   logic        ext_edge;
   logic        rd_ok;
   logic        wr_ok;
   logic [7:0]  ctl_view;

   assign half_prog = CW'(PROG_CYCLES / 2);

   nv_byte_array #(
      .DEPTH (256)
   ) u_array (
      .core_clk_i (core_clk_i),
      .wr_en_i    (arr_we),
      .addr_i     (arr_addr),
      .wdata_i    (arr_wdata),
      .rdata_o    (arr_rdata)
   );

   always_comb begin
      s_nxt    = s_r;
      // one take per request: the registered ack masks the held strobe
      bus_take = cyc_i && stb_i && !s_r.ack;
      bus_wr   = bus_take && we_i && sel_i[0];
      bus_rd   = bus_take && !we_i;
      wb       = dat_i[7:0];
      busy     = (s_r.nv != NV_IDLE);
      arr_we   = 1'b0;
      arr_addr = s_r.addr;
      arr_wdata = s_r.data;
      ext_go   = 1'b0;

      // edge taken from the second and third stages, never from the first
      ext_edge = s_r.ext_q2.req && !s_r.ext_q3;
      // read trigger only for data space
      rd_ok    = wb[`CTL_READ] && !wb[`CTL_PROG_SEL] && !wb[`CTL_CFG_SEL];
      // permit must already stand from an earlier write, not from this one
      wr_ok    = s_r.permit && (s_r.key == KEY_ARMED) && s_r.pwrt_done;

      // control register as software sees it; bit 5 reads zero
      ctl_view                 = 8'h00;
      ctl_view[`CTL_PROG_SEL]  = s_r.prog_sel;
      ctl_view[`CTL_CFG_SEL]   = s_r.cfg_sel;
      ctl_view[`CTL_ROW_ERASE] = s_r.row_erase;
      ctl_view[`CTL_ABORT]     = s_r.abort;
      ctl_view[`CTL_PERMIT]    = s_r.permit;
      ctl_view[`CTL_WRITE]     = s_r.wr;
      ctl_view[`CTL_READ]      = s_r.rd;

      // pins cross two flops before use
      s_nxt.ext_q1   = ext_req_i;
      s_nxt.ext_q2   = s_r.ext_q1;
      s_nxt.ext_q3   = s_r.ext_q2.req;
      s_nxt.cp_q1    = code_protect_i;
      s_nxt.cp_q2    = s_r.cp_q1;
      s_nxt.abrst_q1 = write_aborted_by_reset_i;
      s_nxt.abrst_q2 = s_r.abrst_q1;

      s_nxt.ack      = bus_take;
      s_nxt.rd       = 1'b0;
      s_nxt.rd_land  = 1'b0;
      s_nxt.ext_land = 1'b0;

      // power-up hold timer
      // writes stay blocked until it runs out; it restarts at every reset
      if (!s_r.pwrt_done) begin
         s_nxt.pwrt_cnt = s_r.pwrt_cnt + CW'(1);
         if (s_r.pwrt_cnt == CW'(PWRT_CYCLES - 1)) begin
            s_nxt.pwrt_done = 1'b1;
         end
      end

      // reset-ended write reported from outside
      if (s_r.abrst_q2) begin
         s_nxt.abort = 1'b1;
      end

      // read data lands one cycle after the trigger
      if (s_r.rd_land) begin
         s_nxt.data = arr_rdata;
      end

      // bus reads
      if (bus_rd) begin
         unique case (adr_i)
            `OFS_NV_ADDRESS:    s_nxt.rdat = s_r.addr;
            `OFS_NV_DATA:       s_nxt.rdat = s_r.data;
            `OFS_UNLOCK_KEY:    s_nxt.rdat = 8'h00;
            `OFS_NV_CONTROL:    s_nxt.rdat = ctl_view;
            // bit 0 of each group 2 register is unimplemented
            `OFS_IRQ_PRIORITY2: begin
               s_nxt.rdat = {s_r.irq_prio[7:1], 1'b0};
            end
            `OFS_IRQ_FLAGS2: begin
               s_nxt.rdat = {s_r.irq_flags[7:1], 1'b0};
            end
            `OFS_IRQ_ENABLES2: begin
               s_nxt.rdat = {s_r.irq_en[7:1], 1'b0};
            end
            default:            s_nxt.rdat = 8'h00;
         endcase
      end

      // any bus write other than the expected key breaks the sequence
      if (bus_wr && adr_i != `OFS_UNLOCK_KEY &&
          !(adr_i == `OFS_NV_CONTROL && s_r.key == KEY_ARMED)) begin
         s_nxt.key = KEY_IDLE;
      end

      if (bus_wr) begin
         unique case (adr_i)
            `OFS_NV_ADDRESS: begin
               if (!busy) s_nxt.addr = wb;
            end
            `OFS_NV_DATA: begin
               if (!busy) s_nxt.data = wb;
            end
            `OFS_UNLOCK_KEY: begin
               unique case (s_r.key)
                  KEY_IDLE:  s_nxt.key = (wb == `KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
                  KEY_GOT1:  s_nxt.key = (wb == `KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
                  // a third key write disarms rather than re-arms
                  KEY_ARMED: s_nxt.key = KEY_IDLE;
                  default:   s_nxt.key = KEY_IDLE;
               endcase
            end
            `OFS_NV_CONTROL: begin
               if (!busy) begin
                  s_nxt.prog_sel  = wb[`CTL_PROG_SEL];
                  s_nxt.cfg_sel   = wb[`CTL_CFG_SEL];
                  s_nxt.row_erase = wb[`CTL_ROW_ERASE];
                  s_nxt.abort     = wb[`CTL_ABORT] || s_r.abrst_q2; // set wins over clear
                  s_nxt.permit    = wb[`CTL_PERMIT];
                  if (rd_ok) begin
                     s_nxt.rd      = 1'b1;
                     s_nxt.rd_land = 1'b1;
                  end
                  if (wb[`CTL_WRITE]) begin
                     if (wr_ok) begin
                        s_nxt.wr       = 1'b1;
                        s_nxt.nv       = NV_ERASE;
                        s_nxt.prog_cnt = '0;
                     end else begin
                        s_nxt.abort = 1'b1;
                     end
                  end
               end
               // a locked control write still disarms the keys
               s_nxt.key = KEY_IDLE;
            end
            `OFS_IRQ_PRIORITY2: begin
               s_nxt.irq_prio = wb;
            end
            `OFS_IRQ_FLAGS2: begin
               // a done event in this cycle is set again below and wins
               s_nxt.irq_flags = wb;
            end
            `OFS_IRQ_ENABLES2: begin
               s_nxt.irq_en = wb;
            end
            default: ;
         endcase
      end

      // self-timed erase then program
      unique case (s_r.nv)
         NV_IDLE: ;
         NV_ERASE: begin
            s_nxt.prog_cnt = s_r.prog_cnt + CW'(1);
            if (s_r.prog_cnt == half_prog) begin
               arr_we         = 1'b1;
               arr_wdata      = 8'hff;
               s_nxt.nv       = NV_PROG;
               s_nxt.prog_cnt = '0;
            end
         end
         NV_PROG: begin
            s_nxt.prog_cnt = s_r.prog_cnt + CW'(1);
            if (s_r.prog_cnt == CW'(PROG_CYCLES - 1) - half_prog) begin
               arr_we         = 1'b1;
               s_nxt.nv       = NV_IDLE;
               s_nxt.wr        = 1'b0;
               s_nxt.row_erase = 1'b0;
               // a late reset report still marks the byte as suspect
               s_nxt.abort     = s_r.abrst_q2;
               s_nxt.irq_flags[`IRQ_WDONE_BIT] = 1'b1;
            end
         end
         default: s_nxt.nv = NV_IDLE;
      endcase

      // external programming port, gated by code protect
      s_nxt.ext_blocked = s_r.cp_q2;
      // the array has one port: a request meeting a cpu read or write is dropped
      if (ext_edge && !s_r.cp_q2 && !busy && !s_r.rd_land && !s_nxt.rd_land) begin
         ext_go = 1'b1;
      end
      if (ext_go) begin
         arr_addr  = s_r.ext_q2.addr;
         arr_wdata = s_r.ext_q2.wdata;
         arr_we    = s_r.ext_q2.we && s_r.pwrt_done;
         s_nxt.ext_land = !s_r.ext_q2.we;
      end
      if (s_r.ext_land) begin
         s_nxt.ext_rdata = arr_rdata;
      end

      s_nxt.irq_prio[0]  = 1'b0;
      s_nxt.irq_flags[0] = 1'b0;
      s_nxt.irq_en[0]    = 1'b0;
   end

   // a hardware set of the done flag overrides a same-cycle software clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s_r           <= '0;
         s_r.key       <= KEY_IDLE;
         s_r.nv        <= NV_IDLE;
         s_r.permit    <= 1'b0;
         s_r.pwrt_cnt  <= '0;
         s_r.pwrt_done <= 1'b0;
         s_r.irq_flags <= `RST_IRQ_GROUP2;
         s_r.irq_en    <= `RST_IRQ_GROUP2;
         s_r.irq_prio  <= `RST_IRQ_GROUP2;
      end else begin
         s_r <= s_nxt;
      end
   end

   // byte registers sit on lane 0; upper lanes read zero
   assign dat_o            = {24'h000000, s_r.rdat};
   assign ack_o            = s_r.ack;
   assign ext_rdata_o      = s_r.ext_rdata;
   assign ext_blocked_o    = s_r.ext_blocked;
   assign write_done_irq_o = s_r.irq_flags[`IRQ_WDONE_BIT] && s_r.irq_en[`IRQ_WDONE_BIT];

endmodule

`default_nettype wire

//--- rtl/nv_access_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz core clock and a word-aligned wishbone slave
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH

// byte addresses on the wishbone bus
`define OFS_NV_ADDRESS      8'h00
`define OFS_NV_DATA         8'h04
`define OFS_UNLOCK_KEY      8'h08
`define OFS_NV_CONTROL      8'h0c
`define OFS_IRQ_PRIORITY2   8'h10
`define OFS_IRQ_FLAGS2      8'h14
`define OFS_IRQ_ENABLES2    8'h18

// control register bit positions
`define CTL_PROG_SEL        7
`define CTL_CFG_SEL         6
`define CTL_ROW_ERASE       4
`define CTL_ABORT           3
`define CTL_PERMIT          2
`define CTL_WRITE           1
`define CTL_READ            0

// interrupt group 2 bit of the write-done source
`define IRQ_WDONE_BIT       4

// unlock keys
`define KEY_FIRST           8'h55
`define KEY_SECOND          8'haa

// reset values
`define RST_CONTROL         8'h00
`define RST_IRQ_GROUP2      8'h00

// timing: clock rate, programming time, power-up hold
`define CLK_HZ              20000000
`define PROG_TIME_US        4000
`define PROG_CYCLES         ((`PROG_TIME_US * (`CLK_HZ / 1000000)))
`define PWRT_TIME_US        65600
`define PWRT_CYCLES         ((`PWRT_TIME_US * (`CLK_HZ / 1000000)))

`endif

//--- rtl/nv_access_pkg.sv
// types shared by the eeprom access controller and its array
// assumes the constants header is included alongside
package nv_access_pkg;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_GOT1  = 2'b01,
      KEY_ARMED = 2'b10
   } key_state_t;

   typedef enum logic [1:0] {
      NV_IDLE   = 2'b00,
      NV_ERASE  = 2'b01,
      NV_PROG   = 2'b10
   } nv_state_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } array_req_t;

   typedef struct packed {
      logic       req;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ext_req_t;

endpackage

//--- rtl/nv_byte_array.sv
// byte-wide eeprom array model, 256 locations, registered read data
// assumes one request per cycle from the controller
`timescale 1ns/1ps
`default_nettype none

module nv_byte_array #(
   parameter int DEPTH = 256
) (
   // clock
   input  wire logic                     core_clk_i,
   // access
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] addr_i,
   input  wire logic [7:0]               wdata_i,
   output logic      [7:0]               rdata_o
);

   logic [7:0] mem [DEPTH];

   // nonvolatile contents: no reset on purpose
   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end

endmodule

`default_nettype wire

//--- verification/data_eeprom_access_ctrl_tb.sv
// self-checking bench for the eeprom access controller
// assumes short programming and hold counts set by parameter
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_consts.svh"
module data_eeprom_access_ctrl_tb;
   import nv_access_pkg::*;
   localparam int PROG = 30;
   localparam int HOLD = 40;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00, ext_rdata_o, q;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic        ack_o, ext_blocked_o, write_done_irq_o;
   logic        code_protect_i = 1'b0, write_aborted_by_reset_i = 1'b0;
   ext_req_t    ext_req_i;
   int          errors = 0, samples_checked = 0, cycles = 0;
   always #25 core_clk_i = ~core_clk_i;
   data_eeprom_access_ctrl #(.PROG_CYCLES(PROG), .PWRT_CYCLES(HOLD)) dut_u (.core_clk_i,
      .rst_n_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .code_protect_i, .write_aborted_by_reset_i, .ext_req_i, .ext_rdata_o,
      .ext_blocked_o, .write_done_irq_o);
   ext_port_model ext_u (.core_clk_i, .ext_rdata_i(ext_rdata_o), .ext_req_o(ext_req_i));
   task automatic check(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // classic cycle; ack and data taken at the same edge
   task automatic wb(input logic w, input logic [7:0] a, d);
      @(posedge core_clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
      @(posedge core_clk_i iff ack_o === 1'b1);
      q = dat_o[7:0];
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask
   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 8'h00);
   endtask
   task automatic unlock_go(input logic [7:0] k2);
      wb(1'b1, `OFS_UNLOCK_KEY, `KEY_FIRST);
      wb(1'b1, `OFS_UNLOCK_KEY, k2);
      wb(1'b1, `OFS_NV_CONTROL, 8'h06);
   endtask
   task automatic s_hold;
      rd(`OFS_NV_CONTROL);
      check(q, 8'h00);
      wb(1'b1, `OFS_NV_ADDRESS, 8'h21);
      wb(1'b1, `OFS_NV_CONTROL, 8'h04);
      unlock_go(`KEY_SECOND);
      rd(`OFS_NV_CONTROL);
      check(q, 8'h0c);
      repeat (HOLD) @(posedge core_clk_i);
   endtask
   task automatic s_write(input logic [7:0] a, d, input logic prot);
      code_protect_i <= prot;
      wb(1'b1, `OFS_NV_ADDRESS, a);
      wb(1'b1, `OFS_NV_DATA, d);
      wb(1'b1, `OFS_NV_CONTROL, 8'h04);
      unlock_go(`KEY_SECOND);
      wb(1'b1, `OFS_NV_ADDRESS, ~a);
      wb(1'b1, `OFS_NV_DATA, ~d);
      wb(1'b1, `OFS_NV_CONTROL, 8'h00);
      rd(`OFS_NV_CONTROL);
      check(q & 8'hf7, 8'h06);
      do rd(`OFS_NV_CONTROL); while (q[1] === 1'b1);
      check(q, 8'h04);
      rd(`OFS_NV_DATA);
      check(q, d);
      rd(`OFS_IRQ_FLAGS2);
      check(q, 8'h10);
      wb(1'b1, `OFS_IRQ_ENABLES2, 8'h10);
      check({7'h0, write_done_irq_o}, 8'h01);
      wb(1'b1, `OFS_IRQ_FLAGS2, 8'h00);
      check({7'h0, write_done_irq_o}, 8'h00);
      // permit dropped again with the read, as software should
      wb(1'b1, `OFS_NV_CONTROL, 8'h01);
      rd(`OFS_NV_DATA);
      check(q, d);
      rd(`OFS_NV_ADDRESS);
      check(q, a);
   endtask
   task automatic s_refuse;
      wb(1'b1, `OFS_NV_CONTROL, 8'h00);
      unlock_go(`KEY_SECOND);
      rd(`OFS_NV_CONTROL);
      check(q & 8'h06, 8'h04);
      unlock_go(8'h5a);
      rd(`OFS_NV_CONTROL);
      check(q & 8'h06, 8'h04);
      wb(1'b1, `OFS_UNLOCK_KEY, `KEY_FIRST);
      wb(1'b1, `OFS_NV_ADDRESS, 8'h21);
      wb(1'b1, `OFS_UNLOCK_KEY, `KEY_SECOND);
      wb(1'b1, `OFS_NV_CONTROL, 8'h06);
      rd(`OFS_NV_CONTROL);
      check(q & 8'h06, 8'h04);
   endtask
   task automatic s_select;
      wb(1'b1, `OFS_NV_DATA, 8'h5a);
      wb(1'b1, `OFS_NV_CONTROL, 8'h81);
      wb(1'b1, `OFS_NV_CONTROL, 8'h41);
      rd(`OFS_NV_DATA);
      check(q, 8'h5a);
      rd(`OFS_NV_CONTROL);
      check(q, 8'h40);
      wb(1'b1, `OFS_NV_CONTROL, 8'h42);
      rd(`OFS_NV_CONTROL);
      check(q, 8'h48);
      rd(`OFS_UNLOCK_KEY);
      check(q, 8'h00);
      rd(8'h1c);
      check(q, 8'h00);
      wb(1'b1, `OFS_NV_CONTROL, 8'h00);
      write_aborted_by_reset_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      write_aborted_by_reset_i <= 1'b0;
      rd(`OFS_NV_CONTROL);
      check(q, 8'h08);
   endtask
   task automatic s_ext;
      ext_u.access(1'b0, 8'hff, 8'h00, q);
      check(q, 8'h00);
      code_protect_i <= 1'b1;
      ext_u.access(1'b1, 8'hff, 8'h99, q);
      check({7'h0, ext_blocked_o}, 8'h01);
      ext_u.access(1'b0, 8'h33, 8'h00, q);
      check(q, 8'h00);
      code_protect_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      ext_u.access(1'b0, 8'hff, 8'h00, q);
      check(q, 8'h00);
      ext_u.access(1'b0, 8'h33, 8'h00, q);
      check(q, 8'hc3);
   endtask
   task automatic report_and_stop;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // generous ceiling; the sequence needs well under two thousand cycles
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      s_hold();
      s_write(8'h33, 8'hc3, 1'b1);
      s_write(8'hff, 8'h00, 1'b0);
      s_refuse();
      s_select();
      s_ext();
      report_and_stop();
   end
endmodule
`default_nettype wire

//--- verification/ext_port_model.sv
// external programming port model, one byte access per call
// assumes the controller syncs req and answers within a few cycles
`timescale 1ns/1ps
`default_nettype none
module ext_port_model (
   // clock
   input  wire logic                   core_clk_i,
   // port
   input  wire logic [7:0]             ext_rdata_i,
   output var nv_access_pkg::ext_req_t ext_req_o
);
   import nv_access_pkg::*;
   initial ext_req_o = '0;
   // request held past the two-flop sync and answer delay
   task automatic access(input logic we, input logic [7:0] a, d, output logic [7:0] rd);
      @(posedge core_clk_i);
      ext_req_o <= '{1'b1, we, a, d};
      repeat (8) @(posedge core_clk_i);
      rd = ext_rdata_i;
      // released fields show no stale value
      ext_req_o <= '{1'b0, ~we, ~a, ~d};
      repeat (4) @(posedge core_clk_i);
   endtask
endmodule
`default_nettype wire

//--- verification/nv_access_ctrl_asserts.sv
// port checker for the eeprom access controller
// assumes a classic wishbone master, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_consts.svh"
module nv_access_ctrl_asserts (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   // wishbone
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // protect, external port, interrupt
   input wire logic        code_protect_i,
   input wire logic [7:0]  ext_rdata_o,
   input wire logic        ext_blocked_o,
   input wire logic        write_done_irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic rd_take = cyc_i && stb_i && !we_i && !ack_o;
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_key_zero; rd_take && adr_i == `OFS_UNLOCK_KEY |=> dat_o == 32'h0; endproperty
   a_key_zero: assert property (p_key_zero) else $error("key port not zero");
   property p_rd_clear;
      rd_take && adr_i == `OFS_NV_CONTROL |=> dat_o[0] == 1'b0 && dat_o[31:8] == 24'h0;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read bit stuck");
   property p_blk_on; code_protect_i [*4] |=> ext_blocked_o; endproperty
   a_blk_on: assert property (p_blk_on) else $error("protect not applied");
   property p_blk_off; !code_protect_i [*4] |=> !ext_blocked_o; endproperty
   a_blk_off: assert property (p_blk_off) else $error("protect not lifted");
   property p_blk_hold; ext_blocked_o [*6] |=> $stable(ext_rdata_o); endproperty
   a_blk_hold: assert property (p_blk_hold) else $error("blocked port answered");
   // only a bus write may drop the flag or its enable
   property p_done_hold; write_done_irq_o && !(cyc_i && stb_i && we_i) |=> write_done_irq_o;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done flag lost");
   c_done: cover property ($rose(write_done_irq_o));
   c_blk: cover property (ext_blocked_o);
   c_ctl: cover property (rd_take && adr_i == `OFS_NV_CONTROL);
endmodule
bind data_eeprom_access_ctrl nv_access_ctrl_asserts chk_u (.core_clk_i, .rst_n_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .code_protect_i, .ext_rdata_o, .ext_blocked_o,
   .write_done_irq_o);
`default_nettype wire
